// ==== logic/lane_steer_regs.svh ====
`ifndef LANE_STEER_REGS_SVH
`define LANE_STEER_REGS_SVH
`define MEM_ADDR_W      20
`define IO_ADDR_W       16
`define IO_DIRECT_MAX   16'h00FF
`define VEC_LAST        20'h003FF
`define MIN_T_STATES    4
`define ST_INTERRUPT_ACKNOWLEDGE_CYCLE         3'h0
`define ST_IO_RD        3'h1
`define ST_IO_WR        3'h2
`define ST_HALT         3'h3
`define ST_FETCH        3'h4
`define ST_MEM_RD       3'h5
`define ST_MEM_WR       3'h6
`define ST_IDLE         3'h7
`endif

// ==== logic/lane_steer_pkg.sv ====
package lane_steer_pkg;
    typedef enum logic [2:0] {
        K_MEM_RD = 3'h0,
        K_MEM_WR = 3'h1,
        K_IO_RD  = 3'h2,
        K_IO_WR  = 3'h3,
        K_FETCH  = 3'h4,
        K_INTERRUPT_ACKNOWLEDGE_CYCLE   = 3'h5,
        K_VECTOR = 3'h6,
        K_STACK  = 3'h7
    } req_kind_t;

    typedef struct packed {
        req_kind_t   kind;
        logic        word;
        logic        port_direct;
        logic [19:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [19:0] addr;
        logic        upper_byte_enable_n;
        logic [2:0]  status;
        logic        addr_valid;
        logic        read_n;
        logic        write_n;
    } bus_pins_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'h0,
        T_1    = 3'h1,
        T_2    = 3'h2,
        T_3    = 3'h3,
        T_4    = 3'h4
    } t_state_t;
endpackage : lane_steer_pkg

// ==== logic/bus_width_lane_steering.sv ====
`timescale 1ns/100ps
`include "lane_steer_regs.svh"
// Notes on behaviour
// - 1 Mbyte memory, 64 Kbyte I/O, word=two bytes
// - even bytes low half, odd bytes high
// - even byte: a0 low, upper enable high
// - odd byte: upper enable low, a0 high
// - even word: both low, one cycle
// - odd word splits: upper then lower
// - byte read floats whole bus
// - 16-bit bus byte write drives both halves, 8-bit bus AD7:0 only
// - 8-bit bus uses AD7:0, eight lines
// - 8-bit word: two cycles, addr then +1
// - I/O cycles force A19:16 zero
// - direct ports 0-255, indirect full space
// - acknowledge: no address, lower half data
// - vectors: even words within 0H-3FFH
// - stack transfers are even-addressed words
// - address and status, then strobe
// - end: capture read, release write
// - cycle lasts at least four clocks
module bus_width_lane_steering
    import lane_steer_pkg::*;
#(
    parameter int MIN_T = `MIN_T_STATES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        bus16_i,
    input  wire logic        req_valid_i,
    input  wire bus_req_t    req_i,
    input  wire logic        ready_i,
    input  wire logic [15:0] ad_in_i,
    output logic             req_ready_o,
    output logic             done_o,
    output logic [15:0]      rdata_o,
    output bus_pins_t        pins_o,
    output logic [15:0]      ad_out_o,
    output logic [15:0]      ad_oe_o,
    output logic             output_clock_o
);
    logic        rst_s1_reg;
    logic        rst_s1_next;
    logic        rst_s2_reg;
    logic        rst_s2_next;
    logic [2:0]  rdy_sync_reg;
    logic [2:0]  rdy_sync_next;
    logic        rdy_ok;
    t_state_t    t_reg, t_next;
    bus_req_t    cur_reg, cur_next;
    logic        second_reg, second_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic        busy_reg, busy_next;
    logic        req_ready_reg, req_ready_next;
    logic        done_reg, done_next;
    logic [15:0] rdata_reg, rdata_next;
    bus_pins_t   pins_reg, pins_next;
    logic [15:0] ad_out_reg, ad_out_next;
    logic [15:0] ad_oe_reg, ad_oe_next;
    logic        oclk_reg;
    logic        oclk_next;
    logic [19:0] eaddr;
    logic        is_write, is_read, odd_split, need_two, hi_lane, first_hi;
    logic [7:0]  byte_out;
    logic        full_word;

    // status code for each request kind
    function automatic logic [2:0] status_of(input req_kind_t k,
                                             input logic w);
        case (k)
            K_MEM_RD: status_of = `ST_MEM_RD;
            K_MEM_WR: status_of = `ST_MEM_WR;
            K_IO_RD:  status_of = `ST_IO_RD;
            K_IO_WR:  status_of = `ST_IO_WR;
            K_FETCH:  status_of = `ST_FETCH;
            K_INTERRUPT_ACKNOWLEDGE_CYCLE:   status_of = `ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
            K_VECTOR: status_of = `ST_MEM_RD;
            K_STACK:  status_of = w ? `ST_MEM_WR : `ST_MEM_RD;
            default:  status_of = `ST_IDLE;
        endcase
    endfunction : status_of

    // request address with space limits applied
    function automatic logic [19:0] map_addr(input bus_req_t r);
        logic [19:0] a;
        a = r.addr;
        case (r.kind)
            K_IO_RD, K_IO_WR: begin
                a[19:16] = 4'h0;
                if (r.port_direct)
                    a[15:8] = 8'h00;
            end
            K_VECTOR: a = {10'h000, r.addr[9:1], 1'b0};
            K_STACK:  a = {r.addr[19:1], 1'b0};
            default:  a = r.addr;
        endcase
        map_addr = a;
    endfunction : map_addr

    // byte taken from the lane that the address picks
    function automatic logic [7:0] lane_pick(input logic hi,
                                             input logic [15:0] d);
        lane_pick = hi ? d[15:8] : d[7:0];
    endfunction : lane_pick

    // reset release through two stages
    always_comb begin
        rst_s1_next = 1'b1;
        rst_s2_next = rst_s1_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= rst_s1_next;
            rst_s2_reg <= rst_s2_next;
        end
    end

    // ready sampler and output clock divider
    always_comb begin
        rdy_sync_next = {rdy_sync_reg[1:0], ready_i};
        oclk_next     = ~oclk_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rdy_sync_reg <= 3'h0;
            oclk_reg     <= 1'b0;
        end else begin
            rdy_sync_reg <= rdy_sync_next;
            oclk_reg     <= oclk_next;
        end
    end
    assign rdy_ok = rdy_sync_reg[1] & rdy_sync_reg[2];

    // lane decode for the current byte
    always_comb begin
        eaddr     = cur_reg.addr;
        is_write  = (cur_reg.kind == K_MEM_WR) || (cur_reg.kind == K_IO_WR)
                    || ((cur_reg.kind == K_STACK) && cur_reg.port_direct);
        is_read   = !is_write;
        odd_split = bus16_i && cur_reg.word && cur_reg.addr[0];
        need_two  = cur_reg.word && (!bus16_i || cur_reg.addr[0]);
        full_word = bus16_i && cur_reg.word && !need_two;
        first_hi  = odd_split && !second_reg;
        if (need_two && second_reg)
            eaddr = cur_reg.addr + 20'h00001;
        hi_lane   = bus16_i && eaddr[0];
        byte_out  = (need_two && second_reg) ? cur_reg.wdata[15:8]
                                             : cur_reg.wdata[7:0];
    end

    // bus cycle sequencer
    always_comb begin
        t_next         = t_reg;
        cur_next       = cur_reg;
        second_next    = second_reg;
        cnt_next       = cnt_reg;
        busy_next      = busy_reg;
        req_ready_next = 1'b0;
        done_next      = 1'b0;
        rdata_next     = rdata_reg;
        pins_next      = pins_reg;
        ad_out_next    = ad_out_reg;
        ad_oe_next     = ad_oe_reg;
        case (t_reg)
            T_IDLE: begin
                pins_next.status  = `ST_IDLE;
                pins_next.read_n  = 1'b1;
                pins_next.write_n = 1'b1;
                if (!busy_reg && req_valid_i && !req_ready_reg) begin
                    cur_next          = req_i;
                    cur_next.addr     = map_addr(req_i);
                    if (req_i.kind == K_VECTOR || req_i.kind == K_STACK
                        || req_i.kind == K_FETCH && bus16_i)
                        cur_next.word = 1'b1;
                    second_next    = 1'b0;
                    busy_next      = 1'b1;
                    req_ready_next = 1'b1;
                end else if (busy_reg) begin
                    t_next = T_1;
                end
            end
            T_1: begin
                pins_next.status     = status_of(cur_reg.kind,
                                                 cur_reg.port_direct);
                pins_next.addr_valid = (cur_reg.kind != K_INTERRUPT_ACKNOWLEDGE_CYCLE);
                pins_next.addr       = (cur_reg.kind == K_INTERRUPT_ACKNOWLEDGE_CYCLE) ? 20'h00000
                                                                : eaddr;
                if (!bus16_i) begin
                    pins_next.upper_byte_enable_n = 1'b1;
                end else if (cur_reg.kind == K_INTERRUPT_ACKNOWLEDGE_CYCLE) begin
                    pins_next.upper_byte_enable_n = 1'b1;
                end else if (full_word) begin
                    pins_next.upper_byte_enable_n = 1'b0;
                end else if (first_hi) begin
                    pins_next.upper_byte_enable_n = 1'b0;
                end else begin
                    pins_next.upper_byte_enable_n = !eaddr[0];
                end
                ad_out_next = {eaddr[15:0]};
                ad_oe_next  = 16'hFFFF;
                cnt_next    = 3'h1;
                t_next      = T_2;
            end
            T_2: begin
                pins_next.addr_valid = 1'b0;
                if (is_read) begin
                    ad_oe_next       = 16'h0000;
                    pins_next.read_n = 1'b0;
                end else begin
                    ad_oe_next        = bus16_i ? 16'hFFFF : 16'h00FF;
                    pins_next.write_n = 1'b0;
                    if (full_word)
                        ad_out_next = cur_reg.wdata;
                    else
                        ad_out_next = {byte_out, byte_out};
                end
                cnt_next = cnt_reg + 3'h1;
                t_next   = T_3;
            end
            T_3: begin
                if (cnt_reg < 3'(MIN_T - 2))
                    cnt_next = cnt_reg + 3'h1;
                else if (rdy_ok)
                    t_next = T_4;
            end
            T_4: begin
                pins_next.read_n  = 1'b1;
                pins_next.write_n = 1'b1;
                pins_next.status  = `ST_IDLE;
                ad_oe_next        = 16'h0000;
                if (is_read) begin
                    if (full_word)
                        rdata_next = ad_in_i;
                    else if (need_two && second_reg)
                        rdata_next[15:8] = lane_pick(hi_lane, ad_in_i);
                    else
                        rdata_next[7:0] = lane_pick(hi_lane,
                                                    ad_in_i);
                    if (cur_reg.kind == K_INTERRUPT_ACKNOWLEDGE_CYCLE)
                        rdata_next[7:0] = ad_in_i[7:0];
                end
                if (need_two && !second_reg) begin
                    second_next = 1'b1;
                    t_next      = T_1;
                end else begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    t_next    = T_IDLE;
                end
            end
            default: t_next = T_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            t_reg         <= T_IDLE;
            cur_reg       <= '0;
            second_reg    <= 1'b0;
            cnt_reg       <= 3'h0;
            busy_reg      <= 1'b0;
            req_ready_reg <= 1'b0;
            done_reg      <= 1'b0;
            rdata_reg     <= 16'h0000;
            pins_reg      <= '{addr: 20'h00000, upper_byte_enable_n: 1'b1,
                               status: `ST_IDLE, addr_valid: 1'b0,
                               read_n: 1'b1, write_n: 1'b1};
            ad_out_reg    <= 16'h0000;
            ad_oe_reg     <= 16'h0000;
        end else begin
            t_reg         <= t_next;
            cur_reg       <= cur_next;
            second_reg    <= second_next;
            cnt_reg       <= cnt_next;
            busy_reg      <= busy_next;
            req_ready_reg <= req_ready_next;
            done_reg      <= done_next;
            rdata_reg     <= rdata_next;
            pins_reg      <= pins_next;
            ad_out_reg    <= ad_out_next;
            ad_oe_reg     <= ad_oe_next;
        end
    end

    // outputs straight from registers
    assign req_ready_o    = req_ready_reg;
    assign done_o         = done_reg;
    assign rdata_o        = rdata_reg;
    assign pins_o         = pins_reg;
    assign ad_out_o       = ad_out_reg;
    assign ad_oe_o        = ad_oe_reg;
    assign output_clock_o = oclk_reg;
endmodule : bus_width_lane_steering

// ==== verification/bus_width_lane_steering_asserts.sv ====
`timescale 1ns/100ps
`include "lane_steer_regs.svh"
module lane_steer_chk
    import lane_steer_pkg::*;
#(
    parameter int MIN_T = 4
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        bus16_i,
    input wire logic        done_o,
    input wire bus_pins_t   pins_o,
    input wire logic [15:0] ad_oe_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    io_high_zero_a: assert property (pins_o.addr_valid &&
        (pins_o.status == `ST_IO_RD || pins_o.status == `ST_IO_WR)
        |-> pins_o.addr[19:16] == 4'h0) else $error("io upper address set");
    ack_no_addr_a: assert property (pins_o.status == `ST_INTERRUPT_ACKNOWLEDGE_CYCLE
        |-> !pins_o.addr_valid) else $error("acknowledge with address");
    strobe_after_addr_a: assert property ($fell(pins_o.read_n)
        || $fell(pins_o.write_n) |-> $past(pins_o.addr_valid
        || pins_o.status == `ST_INTERRUPT_ACKNOWLEDGE_CYCLE)) else $error("strobe before address");
    read_float_a: assert property (!pins_o.read_n
        |-> ad_oe_o == 16'h0000) else $error("bus driven during read");
    write_both_a: assert property (bus16_i && !pins_o.write_n
        |-> ad_oe_o == 16'hFFFF) else $error("write not on both halves");
    write_release_a: assert property ($rose(pins_o.write_n)
        |-> ad_oe_o == 16'h0000) else $error("write data kept at end");
    min_cycle_a: assert property ($rose(pins_o.addr_valid)
        |=> (!pins_o.addr_valid && !done_o)[*2] ##1 !pins_o.addr_valid)
        else $error("cycle shorter than four clocks");
    odd_upper_a: assert property (pins_o.addr_valid && bus16_i
        && pins_o.addr[0] |-> !pins_o.upper_byte_enable_n)
        else $error("odd address without upper enable");
    cover property (pins_o.addr_valid && bus16_i && pins_o.addr[0]);
    cover property (!pins_o.write_n && bus16_i);
    cover property (pins_o.status == `ST_INTERRUPT_ACKNOWLEDGE_CYCLE && !pins_o.read_n);
endmodule : lane_steer_chk
bind bus_width_lane_steering lane_steer_chk #(.MIN_T(MIN_T)) lane_steer_chk_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus16_i(bus16_i),
    .done_o(done_o), .pins_o(pins_o), .ad_oe_o(ad_oe_o)
);

// ==== verification/bus_mem_model.sv ====
`timescale 1ns/100ps
module bus_mem_model
    import lane_steer_pkg::*;
#(
    parameter logic [7:0] VEC = 8'h5A
) (
    input  wire logic        clk_sys_i,
    input  wire logic        bus16_i,
    input  wire logic        slow_i,
    input  wire bus_pins_t   pins_i,
    input  wire logic [15:0] ad_i,
    output logic             ready_o,
    output logic [15:0]      ad_o
);
    logic [7:0]  mem [0:255];
    logic [19:0] a_q;
    logic        u_q;
    logic [2:0]  s_q;
    logic [3:0]  w_cnt = 4'h0;
    logic [15:0] last  = 16'h0000;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    always @(posedge clk_sys_i) begin
        if (pins_i.addr_valid) begin
            a_q <= pins_i.addr;
            u_q <= pins_i.upper_byte_enable_n;
        end
        if (pins_i.status != 3'h7) s_q <= pins_i.status;
        w_cnt <= (pins_i.read_n && pins_i.write_n) ? 4'h0 : w_cnt + 4'h1;
        if (!pins_i.read_n) last <= ad_o;
        if (!pins_i.write_n && (!bus16_i || !a_q[0]))
            mem[a_q[7:0]] <= ad_i[7:0];
        if (!pins_i.write_n && bus16_i && !u_q)
            mem[{a_q[7:1], 1'b1}] <= ad_i[15:8];
    end
    always_comb begin
        ready_o = !slow_i || w_cnt > 4'h4;
        if (pins_i.read_n) ad_o = ~last;
        else if (s_q == 3'h0) ad_o = {~VEC, VEC};
        else if (bus16_i)
            ad_o = {mem[{a_q[7:1], 1'b1}], mem[{a_q[7:1], 1'b0}]};
        else ad_o = {~mem[a_q[7:0]], mem[a_q[7:0]]};
    end
endmodule : bus_mem_model

// ==== verification/bus_width_lane_steering_test.sv ====
`timescale 1ns/100ps
module bus_width_lane_steering_test;
    import lane_steer_pkg::*;
    logic        clk_sys_i    = 1'b0;
    logic        rst_n_i      = 1'b0;
    logic        bus16        = 1'b1;
    logic        req_valid    = 1'b0;
    logic        slow         = 1'b0;
    bus_req_t    req          = '0;
    logic        stb_q        = 1'b0;
    logic        ready;
    logic        req_ready;
    logic        done;
    logic        oclk;
    logic [15:0] ad_in;
    logic [15:0] rdata;
    logic [15:0] ad_out;
    logic [15:0] ad_oe;
    bus_pins_t   pins;
    logic [20:0] trace [$];
    int          mismatches   = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    bus_width_lane_steering bus_width_lane_steering_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus16_i(bus16),
        .req_valid_i(req_valid), .req_i(req), .ready_i(ready),
        .ad_in_i(ad_in), .req_ready_o(req_ready), .done_o(done),
        .rdata_o(rdata), .pins_o(pins), .ad_out_o(ad_out),
        .ad_oe_o(ad_oe), .output_clock_o(oclk));
    bus_mem_model bus_mem_model_i (.clk_sys_i(clk_sys_i), .bus16_i(bus16),
        .slow_i(slow), .pins_i(pins), .ad_i(ad_out), .ready_o(ready),
        .ad_o(ad_in));
    always @(posedge clk_sys_i) begin
        stb_q <= !(pins.read_n && pins.write_n);
        if (!stb_q && !(pins.read_n && pins.write_n))
            trace.push_back({pins.upper_byte_enable_n, pins.addr});
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic access(input req_kind_t k, input logic w, pd,
                          input logic [19:0] a, input logic [15:0] d);
        int n;
        trace.delete();
        @(posedge clk_sys_i);
        req_valid <= 1'b1;
        req <= '{k, w, pd, a, d};
        for (n = 0; n < 99 && req_ready !== 1'b1; n++) @(posedge clk_sys_i);
        req_valid <= 1'b0;
        for (n = 0; n < 999 && done !== 1'b1; n++) @(posedge clk_sys_i);
        check("done", done, 1'b1);
    endtask : access
    task automatic word16_scenario();
        logic oclk_prev;
        oclk_prev = oclk;
        @(posedge clk_sys_i);
        check("output clock", oclk, !oclk_prev);
        access(K_MEM_WR, 1'b1, 1'b0, 20'h00010, 16'h1234);
        check("even word pins", trace[0], {1'b0, 20'h00010});
        access(K_MEM_WR, 1'b1, 1'b0, 20'h00021, 16'hABCD);
        check("split cycles", trace.size(), 2);
        check("split first", trace[0], {1'b0, 20'h00021});
        check("split second", trace[1], {1'b1, 20'h00022});
        access(K_MEM_RD, 1'b1, 1'b0, 20'h00021, 16'h0000);
        check("odd word data", rdata, 16'hABCD);
        access(K_MEM_RD, 1'b1, 1'b0, 20'h00010, 16'h0000);
        check("even word data", rdata, 16'h1234);
    endtask : word16_scenario
    task automatic byte16_scenario();
        access(K_MEM_RD, 1'b0, 1'b0, 20'h00032, 16'h0000);
        check("even byte pins", trace[0], {1'b1, 20'h00032});
        access(K_MEM_WR, 1'b0, 1'b0, 20'h00033, 16'h0077);
        check("odd byte pins", trace[0], {1'b0, 20'h00033});
        access(K_MEM_RD, 1'b1, 1'b0, 20'h00032, 16'h0000);
        check("other bank kept", rdata, 16'h7797);
    endtask : byte16_scenario
    task automatic bus8_scenario();
        bus16 <= 1'b0;
        access(K_MEM_WR, 1'b1, 1'b0, 20'h00041, 16'h5678);
        check("word first", trace[0][19:0], 20'h00041);
        check("word second", trace[1][19:0], 20'h00042);
        access(K_MEM_RD, 1'b1, 1'b0, 20'h00041, 16'h0000);
        check("narrow word data", rdata, 16'h5678);
        access(K_MEM_RD, 1'b0, 1'b0, 20'h00041, 16'h0000);
        check("narrow byte cycles", trace.size(), 1);
        bus16 <= 1'b1;
    endtask : bus8_scenario
    task automatic io_scenario();
        req_kind_t kinds [2] = '{K_IO_WR, K_IO_RD};
        foreach (kinds[i]) begin
            access(kinds[i], 1'b0, 1'b0, 20'hF1235, 16'h00C3);
            check("io indirect", trace[0][19:0], 20'h01235);
            access(kinds[i], 1'b0, 1'b1, 20'hFFF80, 16'h003C);
            check("io direct", trace[0][19:0], 20'h00080);
        end
        access(K_INTERRUPT_ACKNOWLEDGE_CYCLE, 1'b0, 1'b0, 20'h00000, 16'h0000);
        check("ack data", rdata[7:0], 8'h5A);
    endtask : io_scenario
    task automatic slow_scenario();
        slow <= 1'b1;
        access(K_VECTOR, 1'b1, 1'b0, 20'hFFFFE, 16'h0000);
        check("vector pins", trace[0], {1'b0, 20'h003FE});
        check("vector data", rdata, 16'h5A5B);
        access(K_STACK, 1'b1, 1'b1, 20'h00050, 16'hBEEF);
        check("push pins", trace[0], {1'b0, 20'h00050});
        access(K_STACK, 1'b1, 1'b0, 20'h00050, 16'h0000);
        check("pop data", rdata, 16'hBEEF);
        slow <= 1'b0;
    endtask : slow_scenario
    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        word16_scenario();
        byte16_scenario();
        bus8_scenario();
        io_scenario();
        slow_scenario();
        complete_run();
    end
endmodule : bus_width_lane_steering_test
